/* File: rtl/rtcc_map.vh */
`ifndef RTCC_MAP_VH
`define RTCC_MAP_VH
// clock location indices (low three address bits of the top eight bytes)
`define RTCC_IDX_CTRL 3'h0
`define RTCC_IDX_SEC 3'h1
`define RTCC_IDX_MIN 3'h2
`define RTCC_IDX_HOUR 3'h3
`define RTCC_IDX_DAY 3'h4
`define RTCC_IDX_DATE 3'h5
`define RTCC_IDX_MON 3'h6
`define RTCC_IDX_YEAR 3'h7
// full byte addresses of the clock locations
`define RTCC_ADDR_CTRL 19'h7fff8
`define RTCC_ADDR_SEC 19'h7fff9
`define RTCC_ADDR_MIN 19'h7fffa
`define RTCC_ADDR_HOUR 19'h7fffb
`define RTCC_ADDR_DAY 19'h7fffc
`define RTCC_ADDR_DATE 19'h7fffd
`define RTCC_ADDR_MON 19'h7fffe
`define RTCC_ADDR_YEAR 19'h7ffff
// upper address bits that select the clock locations
`define RTCC_HIT_PREFIX 16'hffff
// control byte fields
`define RTCC_CTRL_LOAD_BIT 7
`define RTCC_CTRL_FREEZE_BIT 6
`define RTCC_CTRL_SIGN_BIT 5
`define RTCC_CTRL_CAL_MSB 4
// seconds byte: oscillator_stop_bit
`define RTCC_SEC_STOP_BIT 7
// weekday byte: frequency_test_bit
`define RTCC_DAY_TEST_BIT 6
// reset values
`define RTCC_CTRL_RESET 8'h00
`define RTCC_SEC_RESET 8'h80
`define RTCC_ONE_RESET 8'h01
`define RTCC_ZERO_RESET 8'h00
// used-bit masks of the time bytes
`define RTCC_MASK_SEC 8'h7f
`define RTCC_MASK_MIN 8'h7f
`define RTCC_MASK_HOUR 8'h3f
`define RTCC_MASK_DAY 8'h07
`define RTCC_MASK_DATE 8'h3f
`define RTCC_MASK_MON 8'h1f
// timebase: 32768 Hz split as 256 x 128
`define RTCC_OSC_HZ 32768
`define RTCC_STAGE_DIV 256
`define RTCC_STAGE_LAST 7'h7f
`define RTCC_LO_LAST 9'h0ff
// negative trim stretches stage 0 by 128 ticks
`define RTCC_LO_LAST_NEG 9'h17f
// calibration cycle length in minutes
`define RTCC_CAL_CYCLE_MIN 64
// oscillator restart delay
`define RTCC_RESTART_MS 1000
`define RTCC_CLK_KHZ 10000
`define RTCC_RESTART_CYC (`RTCC_RESTART_MS * `RTCC_CLK_KHZ)
`endif

/* File: rtl/rtcc_hif.v */
`timescale 1ns/1ns
`default_nettype none
`include "rtcc_map.vh"
// host write capture for the eight clock locations
module rtcc_hif (
	input wire clk,
	input wire rst,
	input wire ce_n,
	input wire we_n,
	input wire pf,
	input wire [18:0] addr,
	input wire [7:0] din,
	output wire hit,
	output reg wr_stb_r,
	output reg [2:0] wr_idx_r,
	output reg [7:0] wr_data_r
);
	wire active; // write window open
	reg act_r; // window open last cycle
	reg [2:0] cap_idx_r; // address held during window
	reg [7:0] cap_data_r; // data held during window
	reg cap_hit_r; // window aimed at a clock byte
	assign hit = (addr[18:3] == `RTCC_HIT_PREFIX);
	// later falling enable opens, earlier rising enable closes; power fail blocks
	assign active = !ce_n && !we_n && !pf;
	// data is sampled through the window so the last value before the close wins
	always @(posedge clk) begin
		if (rst) begin
			act_r <= 1'b0;
			cap_idx_r <= 3'h0;
			cap_data_r <= 8'h00;
			cap_hit_r <= 1'b0;
			wr_stb_r <= 1'b0;
			wr_idx_r <= 3'h0;
			wr_data_r <= 8'h00;
		end else begin
			act_r <= active;
			if (active) begin
				cap_idx_r <= addr[2:0];
				cap_data_r <= din;
				cap_hit_r <= hit;
			end
			// commit on the close of the window
			wr_stb_r <= act_r && !active && cap_hit_r;
			wr_idx_r <= cap_idx_r;
			wr_data_r <= cap_data_r;
		end
	end
endmodule
`default_nettype wire

/* File: rtl/rtcc_cnt.v */
`timescale 1ns/1ns
`default_nettype none
`include "rtcc_map.vh"
// running bcd counter chain, 24 hour, leap year by year mod 4
module rtcc_cnt (
	input wire clk,
	input wire rst,
	input wire inc,
	input wire load,
	input wire [7:0] ld_sec,
	input wire [7:0] ld_min,
	input wire [7:0] ld_hour,
	input wire [7:0] ld_day,
	input wire [7:0] ld_date,
	input wire [7:0] ld_mon,
	input wire [7:0] ld_year,
	output reg [7:0] sec_r,
	output reg [7:0] min_r,
	output reg [7:0] hour_r,
	output reg [7:0] day_r,
	output reg [7:0] date_r,
	output reg [7:0] mon_r,
	output reg [7:0] year_r
);
	// bcd step with wrap: returns {wrapped, next}
	function [8:0] bcd_step;
		input [7:0] v;
		input [7:0] last;
		input [7:0] first;
		begin
			if (v >= last) begin
				bcd_step = {1'b1, first};
			end else if (v[3:0] >= 4'h9) begin
				bcd_step = {1'b0, v[7:4] + 4'h1, 4'h0};
			end else begin
				bcd_step = {1'b0, v[7:4], v[3:0] + 4'h1};
			end
		end
	endfunction
	reg leap; // year divisible by four
	reg [7:0] mon_last; // last date of current month
	wire [8:0] s_n, m_n, h_n, d_n, dt_n, mo_n, y_n;
	// month length from bcd month and year
	always @* begin
		leap = year_r[4] ? (year_r[3:0] == 4'h2 || year_r[3:0] == 4'h6) :
			(year_r[3:0] == 4'h0 || year_r[3:0] == 4'h4 || year_r[3:0] == 4'h8);
		case (mon_r)
			8'h02: mon_last = leap ? 8'h29 : 8'h28;
			8'h04, 8'h06, 8'h09, 8'h11: mon_last = 8'h30;
			default: mon_last = 8'h31;
		endcase
	end
	// ranges seconds/minutes 00-59, hours 00-23, weekday 01-07
	assign s_n = bcd_step(sec_r, 8'h59, 8'h00);
	assign m_n = bcd_step(min_r, 8'h59, 8'h00);
	assign h_n = bcd_step(hour_r, 8'h23, 8'h00);
	assign d_n = bcd_step(day_r, 8'h07, 8'h01);
	assign dt_n = bcd_step(date_r, mon_last, 8'h01);
	assign mo_n = bcd_step(mon_r, 8'h12, 8'h01);
	assign y_n = bcd_step(year_r, 8'h99, 8'h00);
	// load from the visible bytes wins over a count in the same cycle
	always @(posedge clk) begin
		if (rst) begin
			sec_r <= `RTCC_ZERO_RESET;
			min_r <= `RTCC_ZERO_RESET;
			hour_r <= `RTCC_ZERO_RESET;
			day_r <= `RTCC_ONE_RESET;
			date_r <= `RTCC_ONE_RESET;
			mon_r <= `RTCC_ONE_RESET;
			year_r <= `RTCC_ZERO_RESET;
		end else if (load) begin
			sec_r <= ld_sec & `RTCC_MASK_SEC;
			min_r <= ld_min & `RTCC_MASK_MIN;
			hour_r <= ld_hour & `RTCC_MASK_HOUR;
			day_r <= ld_day & `RTCC_MASK_DAY;
			date_r <= ld_date & `RTCC_MASK_DATE;
			mon_r <= ld_mon & `RTCC_MASK_MON;
			year_r <= ld_year;
		end else if (inc) begin
			sec_r <= s_n[7:0];
			if (s_n[8]) begin
				min_r <= m_n[7:0];
				if (m_n[8]) begin
					hour_r <= h_n[7:0];
					if (h_n[8]) begin
						day_r <= d_n[7:0];
						date_r <= dt_n[7:0];
						if (dt_n[8]) begin
							mon_r <= mo_n[7:0];
							if (mo_n[8]) begin
								year_r <= y_n[7:0];
							end
						end
					end
				end
			end
		end
	end
endmodule
`default_nettype wire

/* File: rtl/rtcc_top.v */
`timescale 1ns/1ns
`default_nettype none
`include "rtcc_map.vh"
// Overview of operation
// - read-freeze bit set stops visible register updates
// - frozen bytes keep time; counters keep running
// - all bytes update together, never split
// - after freeze clears, next update within one second
// - load-enable bit halts updates; host writes time
// - load-enable clear copies visible bytes into counters
// - after load clears, next update one second on
// - reset clears load-enable and read-freeze bits
// - oscillator-stop bit set halts the oscillator
// - stop bit cleared: oscillator restarts after one second
// - stop bit comes out of reset set
// - stop and test bits writable without load-enable
// - 32768 Hz timebase, trim at divide-by-256 stage
// - calibration magnitude is five bits, zero to 31
// - sign bit one speeds, zero slows the clock
// - 64 minute cycle, only first 62 adjustable
// - adjusted minutes equal twice the magnitude
// - adjusted second gains 256 or loses 128 ticks
// - bytes hold 24 hour bcd within ranges
// - write spans later falling to earlier rising enable
// - power fail deselects, blocks writes, floats outputs
module rtcc_top #(
	parameter RESTART_CYC = `RTCC_RESTART_CYC
) (
	input wire CORE_CLK,
	input wire RST,
	input wire CE_N,
	input wire WE_N,
	input wire OE_N,
	input wire [18:0] ADDR,
	input wire [7:0] DQ_IN,
	output reg [7:0] DQ_OUT,
	output reg DQ_OE_N,
	input wire OSC_TICK,
	input wire POWER_FAIL,
	output reg OSC_RUNNING,
	output reg FREQ_TEST_OUT
);
	// read mux for the host read path only; the restart check takes the stop bit straight from the seconds byte
	function [7:0] pick_byte;
		input [2:0] idx;
		input [63:0] bank;
		begin
			pick_byte = bank[idx*8 +: 8];
		end
	endfunction

	// host write path outputs
	wire hit; // address points at a clock byte
	wire wr_stb; // one-cycle write commit
	wire [2:0] wr_idx; // byte being written
	wire [7:0] wr_data; // data being written

	// visible bytes seen by the host
	reg [7:0] ctrl_r; // clock_control
	reg [7:0] sec_vis_r; // seconds_and_stop
	reg [7:0] min_vis_r; // minutes_count
	reg [7:0] hour_vis_r; // hours_count
	reg [7:0] day_vis_r; // weekday_count
	reg [7:0] date_vis_r; // date_count
	reg [7:0] mon_vis_r; // month_count
	reg [7:0] year_vis_r; // year_count
	wire [63:0] bank; // all visible bytes, control at index 0

	// running counters
	wire [7:0] c_sec, c_min, c_hour, c_day, c_date, c_mon, c_year;

	// control decode
	wire load_en; // load-enable bit
	wire freeze; // read-freeze bit
	wire cal_pos; // calibration sign
	wire [4:0] cal_mag; // calibration magnitude
	wire stop_bit; // oscillator_stop_bit
	wire freq_test_bit; // frequency_test_bit

	// load handshake
	reg load_prev_r; // load-enable one cycle back
	reg load_go_r; // copy visible bytes into counters
	wire load_fall; // load-enable just cleared

	// oscillator gating
	reg osc_run_r; // ticks are being counted
	reg [31:0] restart_cnt_r; // delay before restart
	wire tick; // usable oscillator tick

	// divider chain: 256 ticks per stage, 128 stages per second
	reg [8:0] lo_r; // ticks within a stage
	reg [6:0] stage_r; // stage within a second
	reg [8:0] lo_last; // terminal tick count of this stage
	reg [6:0] stage_step; // stages advanced at stage end
	reg [7:0] stage_sum; // stage plus step, carry on top
	wire stage_end; // last tick of a stage
	wire sec_pulse; // one second elapsed

	// calibration cycle
	reg [5:0] cal_min_r; // minute within the 64 minute cycle
	reg min_prev_r; // previous bit of minutes to find rollover
	wire adj_min; // this minute is one of the trimmed ones
	wire adj_sec; // this is the trimmed second

	// update from counters to visible bytes
	reg upd_go_r; // one-cycle update strobe
	wire upd_ok; // updates allowed

	assign bank = {year_vis_r, mon_vis_r, date_vis_r, day_vis_r,
		hour_vis_r, min_vis_r, sec_vis_r, ctrl_r};
	assign load_en = ctrl_r[`RTCC_CTRL_LOAD_BIT];
	assign freeze = ctrl_r[`RTCC_CTRL_FREEZE_BIT];
	assign cal_pos = ctrl_r[`RTCC_CTRL_SIGN_BIT];
	assign cal_mag = ctrl_r[`RTCC_CTRL_CAL_MSB:0]; // unsigned 0..31
	assign stop_bit = sec_vis_r[`RTCC_SEC_STOP_BIT];
	assign freq_test_bit = day_vis_r[`RTCC_DAY_TEST_BIT];

	// host write capture
	rtcc_hif u_hif (
		.clk(CORE_CLK),
		.rst(RST),
		.ce_n(CE_N),
		.we_n(WE_N),
		.pf(POWER_FAIL),
		.addr(ADDR),
		.din(DQ_IN),
		.hit(hit),
		.wr_stb_r(wr_stb),
		.wr_idx_r(wr_idx),
		.wr_data_r(wr_data)
	);

	// running counter chain, loaded when load-enable drops
	rtcc_cnt u_cnt (
		.clk(CORE_CLK),
		.rst(RST),
		.inc(sec_pulse),
		.load(load_go_r),
		.ld_sec(sec_vis_r),
		.ld_min(min_vis_r),
		.ld_hour(hour_vis_r),
		.ld_day(day_vis_r),
		.ld_date(date_vis_r),
		.ld_mon(mon_vis_r),
		.ld_year(year_vis_r),
		.sec_r(c_sec),
		.min_r(c_min),
		.hour_r(c_hour),
		.day_r(c_day),
		.date_r(c_date),
		.mon_r(c_mon),
		.year_r(c_year)
	);

	// load-enable falling edge starts the counter load
	assign load_fall = load_prev_r && !load_en;
	always @(posedge CORE_CLK) begin
		if (RST) begin
			load_prev_r <= 1'b0;
			load_go_r <= 1'b0;
		end else begin
			load_prev_r <= load_en;
			load_go_r <= load_fall;
		end
	end

	// oscillator stop and delayed restart
	// the restart delay runs on the core clock because a stopped crystal gives no edges to count
	always @(posedge CORE_CLK) begin
		if (RST) begin
			osc_run_r <= 1'b0;
			restart_cnt_r <= 32'h0;
		end else if (stop_bit) begin
			osc_run_r <= 1'b0; // halt at once, at any time
			restart_cnt_r <= 32'h0;
		end else if (!osc_run_r) begin
			if (restart_cnt_r >= RESTART_CYC - 1) begin
				osc_run_r <= 1'b1; // about one second after clear
			end else begin
				restart_cnt_r <= restart_cnt_r + 32'h1;
			end
		end
	end
	assign tick = OSC_TICK && osc_run_r;

	// trim decision: first 2*mag minutes of the cycle, first second of the minute
	assign adj_min = ({1'b0, cal_min_r} < {1'b0, cal_mag, 1'b0});
	assign adj_sec = adj_min && (c_sec == 8'h00) && (stage_r == 7'h00);

	// stage length and step for this stage
	always @* begin
		lo_last = `RTCC_LO_LAST;
		stage_step = 7'h01;
		if (adj_sec && cal_pos) begin
			stage_step = 7'h02; // skip one 256-tick stage: 256 ticks gained
		end else if (adj_sec) begin
			lo_last = `RTCC_LO_LAST_NEG; // stretch stage 0 by 128 ticks
		end
		stage_sum = {1'b0, stage_r} + {1'b0, stage_step};
	end
	assign stage_end = tick && (lo_r == lo_last);
	assign sec_pulse = stage_end && stage_sum[7];

	// divider chain, trimmed at the divide-by-256 stage
	// a counter load restarts the second so the next update is a full second away
	always @(posedge CORE_CLK) begin
		if (RST) begin
			lo_r <= 9'h000;
			stage_r <= 7'h00;
		end else if (load_go_r) begin
			lo_r <= 9'h000;
			stage_r <= 7'h00;
		end else if (tick) begin
			if (stage_end) begin
				lo_r <= 9'h000;
				stage_r <= stage_sum[6:0];
			end else begin
				lo_r <= lo_r + 9'h001;
			end
		end
	end

	// 64 minute calibration cycle follows the running minutes
	always @(posedge CORE_CLK) begin
		if (RST) begin
			cal_min_r <= 6'h00;
			min_prev_r <= 1'b0;
		end else begin
			min_prev_r <= c_min[0];
			if (min_prev_r != c_min[0]) begin
				cal_min_r <= cal_min_r + 6'h01; // wraps every 64 minutes
			end
		end
	end

	// updates stop while frozen or loading; a tick missed then is not replayed,
	// so after either bit clears the next update waits for the next second
	assign upd_ok = !freeze && !load_en;
	always @(posedge CORE_CLK) begin
		if (RST) begin
			upd_go_r <= 1'b0;
		end else begin
			upd_go_r <= sec_pulse && upd_ok && !load_go_r;
		end
	end

	// control byte: host writes only; reset clears load and freeze
	always @(posedge CORE_CLK) begin
		if (RST) begin
			ctrl_r <= `RTCC_CTRL_RESET;
		end else if (wr_stb && wr_idx == `RTCC_IDX_CTRL) begin
			ctrl_r <= wr_data;
		end
	end

	// seconds byte: stop bit kept apart from the time field
	// stop bit written without load-enable
	always @(posedge CORE_CLK) begin
		if (RST) begin
			sec_vis_r <= `RTCC_SEC_RESET; // stopped out of reset
		end else if (wr_stb && wr_idx == `RTCC_IDX_SEC) begin
			sec_vis_r <= wr_data;
		end else if (upd_go_r) begin
			sec_vis_r <= {stop_bit, c_sec[6:0]};
		end
	end

	// weekday byte: frequency test bit kept apart from the day field
	always @(posedge CORE_CLK) begin
		if (RST) begin
			day_vis_r <= `RTCC_ONE_RESET;
		end else if (wr_stb && wr_idx == `RTCC_IDX_DAY) begin
			day_vis_r <= wr_data;
		end else if (upd_go_r) begin
			day_vis_r <= {day_vis_r[7], freq_test_bit, c_day[5:0]};
		end
	end

	// remaining time bytes all take the counters in the same cycle
	// a host write in the update cycle wins for its own byte only
	always @(posedge CORE_CLK) begin
		if (RST) begin
			min_vis_r <= `RTCC_ZERO_RESET;
			hour_vis_r <= `RTCC_ZERO_RESET;
			date_vis_r <= `RTCC_ONE_RESET;
			mon_vis_r <= `RTCC_ONE_RESET;
			year_vis_r <= `RTCC_ZERO_RESET;
		end else begin
			if (wr_stb && wr_idx == `RTCC_IDX_MIN) begin
				min_vis_r <= wr_data;
			end else if (upd_go_r) begin
				min_vis_r <= c_min;
			end
			if (wr_stb && wr_idx == `RTCC_IDX_HOUR) begin
				hour_vis_r <= wr_data;
			end else if (upd_go_r) begin
				hour_vis_r <= c_hour;
			end
			if (wr_stb && wr_idx == `RTCC_IDX_DATE) begin
				date_vis_r <= wr_data;
			end else if (upd_go_r) begin
				date_vis_r <= c_date;
			end
			if (wr_stb && wr_idx == `RTCC_IDX_MON) begin
				mon_vis_r <= wr_data;
			end else if (upd_go_r) begin
				mon_vis_r <= c_mon;
			end
			if (wr_stb && wr_idx == `RTCC_IDX_YEAR) begin
				year_vis_r <= wr_data;
			end else if (upd_go_r) begin
				year_vis_r <= c_year;
			end
		end
	end

	// read path: one cycle from select to data, floats on power fail
	// the enable is low while driving
	always @(posedge CORE_CLK) begin
		if (RST) begin
			DQ_OUT <= 8'h00;
			DQ_OE_N <= 1'b1;
		end else begin
			DQ_OUT <= pick_byte(ADDR[2:0], bank);
			DQ_OE_N <= !(!CE_N && !OE_N && WE_N && !POWER_FAIL && hit);
		end
	end

	// status pins; test output is a 512 Hz square while the test bit is set
	always @(posedge CORE_CLK) begin
		if (RST) begin
			OSC_RUNNING <= 1'b0;
			FREQ_TEST_OUT <= 1'b0;
		end else begin
			OSC_RUNNING <= osc_run_r;
			FREQ_TEST_OUT <= freq_test_bit && lo_r[5];
		end
	end
endmodule
`default_nettype wire

/* File: dv/rtcc_top_asserts.sv */
`timescale 1ns/1ns
`default_nettype none
`include "rtcc_map.vh"
// port watcher for the clock byte bus and the oscillator status
module rtcc_top_asserts #(
	parameter RESTART_CYC = 20
) (
	input wire logic CORE_CLK,
	input wire logic RST,
	input wire logic CE_N,
	input wire logic WE_N,
	input wire logic OE_N,
	input wire logic [18:0] ADDR,
	input wire logic [7:0] DQ_IN,
	input wire logic [7:0] DQ_OUT,
	input wire logic DQ_OE_N,
	input wire logic OSC_TICK,
	input wire logic POWER_FAIL,
	input wire logic OSC_RUNNING,
	input wire logic FREQ_TEST_OUT
);
	reg win_r; // window seen at the last edge
	reg [18:0] addr_r; // address of the last window cycle
	reg [7:0] data_r; // data of the last window cycle
	reg [31:0] stop_cnt_r; // idle cycles since the last seconds write
	wire win = !CE_N && !WE_N && !POWER_FAIL; // write window as the device sees it
	wire hit = ADDR[18:3] == `RTCC_HIT_PREFIX; // one of the eight clock bytes
	wire close = win_r && !win; // window just ended, write commits
	// follow the write window; count idle oscillator cycles from a seconds write
	always @(posedge CORE_CLK) begin
		if (RST) begin
			win_r <= 1'b0;
			stop_cnt_r <= 32'h0;
		end else begin
			win_r <= win;
			if (close && addr_r == `RTCC_ADDR_SEC)
				stop_cnt_r <= 32'h0;
			else if (!OSC_RUNNING)
				stop_cnt_r <= stop_cnt_r + 32'h1;
		end
		if (win) begin
			addr_r <= ADDR;
			data_r <= DQ_IN;
		end
	end
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (RST);
	a_reset_quiet_out: assert property (disable iff (1'b0) RST |=> DQ_OE_N && !OSC_RUNNING && !FREQ_TEST_OUT)
		else $error("outputs not quiet under reset");
	a_fail_floats: assert property (POWER_FAIL |=> DQ_OE_N)
		else $error("data driven during power fail");
	a_deselect_floats: assert property (CE_N |=> DQ_OE_N)
		else $error("data driven while deselected");
	a_oe_high_floats: assert property (OE_N |=> DQ_OE_N)
		else $error("data driven with output enable high");
	a_miss_floats: assert property (!hit |=> DQ_OE_N)
		else $error("data driven for a non clock address");
	a_write_floats: assert property (!CE_N && !WE_N |=> DQ_OE_N)
		else $error("data driven during a write");
	a_read_drives: assert property (!CE_N && !OE_N && WE_N && !POWER_FAIL && hit |=> !DQ_OE_N)
		else $error("clock byte read not driven");
	a_stop_halts_osc: assert property (close && addr_r == `RTCC_ADDR_SEC && data_r[7] |-> ##[1:4] !OSC_RUNNING)
		else $error("oscillator kept running after stop");
	a_restart_waits: assert property ($rose(OSC_RUNNING) |-> stop_cnt_r >= RESTART_CYC)
		else $error("oscillator restarted too early");
endmodule
bind rtcc_top rtcc_top_asserts #(.RESTART_CYC(RESTART_CYC)) u_chk (.CORE_CLK(CORE_CLK), .RST(RST), .CE_N(CE_N),
	.WE_N(WE_N), .OE_N(OE_N), .ADDR(ADDR), .DQ_IN(DQ_IN), .DQ_OUT(DQ_OUT), .DQ_OE_N(DQ_OE_N),
	.OSC_TICK(OSC_TICK), .POWER_FAIL(POWER_FAIL), .OSC_RUNNING(OSC_RUNNING), .FREQ_TEST_OUT(FREQ_TEST_OUT));
`default_nettype wire

/* File: dv/rtcc_host.sv */
`timescale 1ns/1ns
`default_nettype none
// host side: asynchronous byte memory cycles, driven on falling edges
module rtcc_host (
	input wire logic clk,
	output var logic ce_n,
	output var logic we_n,
	output var logic oe_n,
	output var logic [18:0] addr,
	output var logic [7:0] din,
	input wire logic [7:0] dq_out,
	input wire logic dq_oe_n
);
	// idle bus from time zero
	initial begin
		ce_n = 1'b1;
		we_n = 1'b1;
		oe_n = 1'b1;
		addr = 19'h0;
		din = 8'h0;
	end
	// write spans both enables low for one edge, then one idle edge
	task wr(input logic [18:0] a, input logic [7:0] d);
		@(negedge clk);
		addr = a;
		din = d; // callers keep unused bits zero
		ce_n = 1'b0;
		we_n = 1'b0;
		@(negedge clk);
		we_n = 1'b1;
		ce_n = 1'b1;
		din = ~d; // released data must not look like the last value
		@(negedge clk);
	endtask
	// read: answer is settled one edge after the request
	task rd(input logic [18:0] a, output logic [7:0] d, output logic z);
		@(negedge clk);
		addr = a;
		ce_n = 1'b0;
		oe_n = 1'b0;
		@(negedge clk);
		// an undriven bus reads as the inverse, so a read that is not answered cannot pass
		d = dq_oe_n ? ~dq_out : dq_out;
		z = dq_oe_n;
		ce_n = 1'b1;
		oe_n = 1'b1;
		@(negedge clk);
	endtask
endmodule
`default_nettype wire

/* File: dv/bcd_rtc_register_control_tb.sv */
`timescale 1ns/1ns
`default_nettype none
`include "rtcc_map.vh"
// directed bench: host cycles against the clock byte block
module bcd_rtc_register_control_tb;
	localparam int RESTART = 20; // shortened oscillator restart
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic osc_tick = 1'b0; // one oscillator tick per cycle once running
	logic power_fail = 1'b0;
	wire ce_n, we_n, oe_n, dq_oe_n, osc_running, freq_test_out;
	wire [18:0] addr;
	wire [7:0] din, dq_out;
	int fail_count = 0;
	int checked = 0;
	int cyc = 0;
	int t0, i;
	logic [7:0] got;
	logic z, seen_hi, seen_lo;
	logic [7:0] exp_rst [8] = '{8'h00, 8'h80, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00};
	logic [7:0] set_v [8] = '{8'h00, 8'h59, 8'h59, 8'h23, 8'h07, 8'h31, 8'h12, 8'h99};
	logic [7:0] new_v [8] = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00};
	rtcc_host host (.clk(core_clk), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .addr(addr), .din(din),
		.dq_out(dq_out), .dq_oe_n(dq_oe_n));
	rtcc_top #(.RESTART_CYC(RESTART)) DUT (.CORE_CLK(core_clk), .RST(rst), .CE_N(ce_n), .WE_N(we_n),
		.OE_N(oe_n), .ADDR(addr), .DQ_IN(din), .DQ_OUT(dq_out), .DQ_OE_N(dq_oe_n), .OSC_TICK(osc_tick),
		.POWER_FAIL(power_fail), .OSC_RUNNING(osc_running), .FREQ_TEST_OUT(freq_test_out));
	// 100 ns clock and a free cycle count for second boundaries
	always #50 core_clk = ~core_clk;
	always @(posedge core_clk) cyc <= cyc + 1;
	task chk(input string n, input logic [7:0] e, input logic [7:0] g);
		checked++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task complete_run();
		if (fail_count == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task wait_to(input int n);
		while (cyc < n) @(negedge core_clk);
	endtask
	// bounded wait on the oscillator status; a timeout ends the run
	task wait_osc(input logic v);
		int k;
		for (k = 0; k < RESTART + 50 && osc_running !== v; k++) @(negedge core_clk);
		chk("OSC_RUNNING", {7'h0, v}, {7'h0, osc_running});
		if (osc_running !== v) complete_run();
	endtask
	initial begin
		repeat (6) @(posedge core_clk);
		@(negedge core_clk);
		rst = 1'b0;
		osc_tick = 1'b1;
		for (i = 0; i < 8; i++) begin
			host.rd({16'hffff, i[2:0]}, got, z);
			chk("reset byte", exp_rst[i], got);
		end
		chk("OSC_RUNNING at reset", 8'h00, {7'h0, osc_running});
		host.wr(`RTCC_ADDR_SEC, 8'h59); // stop cleared without the load bit
		wait_osc(1'b1);
		host.wr(`RTCC_ADDR_CTRL, 8'h80);
		for (i = 1; i < 8; i++) host.wr({16'hffff, i[2:0]}, set_v[i]);
		host.wr(`RTCC_ADDR_CTRL, 8'h00);
		t0 = cyc;
		// freeze plus positive trim of magnitude 2: minute positions 0..3 are trimmed
		host.wr(`RTCC_ADDR_CTRL, 8'h62);
		wait_to(t0 + 32968);
		host.rd(`RTCC_ADDR_SEC, got, z);
		chk("frozen seconds", 8'h59, got);
		// test bit set while frozen, no load bit needed
		host.wr(`RTCC_ADDR_DAY, 8'h41);
		seen_hi = 1'b0;
		seen_lo = 1'b0;
		repeat (80) begin
			@(negedge core_clk);
			if (freq_test_out === 1'b1) seen_hi = 1'b1;
			if (freq_test_out === 1'b0) seen_lo = 1'b1;
		end
		chk("FREQ_TEST_OUT swing", 8'h03, {6'h0, seen_hi, seen_lo});
		host.wr(`RTCC_ADDR_DAY, 8'h01);
		host.wr(`RTCC_ADDR_CTRL, 8'h00);
		// second 00 lost one 256-tick stage, so its update lands 256 cycles early
		wait_to(t0 + 65270);
		host.rd(`RTCC_ADDR_SEC, got, z);
		chk("seconds before update", 8'h59, got);
		wait_to(t0 + 65336);
		host.rd(`RTCC_ADDR_SEC, got, z);
		chk("trimmed second early", 8'h01, got);
		wait_to(t0 + 65736);
		// counters ran on through the freeze and rolled the century over
		for (i = 0; i < 8; i++) begin
			host.rd({16'hffff, i[2:0]}, got, z);
			chk("rolled byte", new_v[i], got);
		end
		power_fail = 1'b1;
		host.wr(`RTCC_ADDR_MIN, 8'h33);
		host.rd(`RTCC_ADDR_MIN, got, z);
		chk("DQ_OE_N in power fail", 8'h01, {7'h0, z});
		power_fail = 1'b0;
		host.rd(`RTCC_ADDR_MIN, got, z);
		chk("minutes kept", 8'h00, got);
		host.rd(19'h00010, got, z);
		chk("DQ_OE_N unmapped", 8'h01, {7'h0, z});
		host.wr(`RTCC_ADDR_SEC, 8'h80);
		wait_osc(1'b0);
		complete_run();
	end
endmodule
`default_nettype wire
